/* common/i2cd_defines.vh */
`ifndef I2CD_DEFINES_VH
`define I2CD_DEFINES_VH
// register byte offsets
`define I2CD_A_CTRL 8'h00
`define I2CD_A_DATA 8'h04
`define I2CD_A_STAT 8'h08
`define I2CD_A_PSC 8'h0C
`define I2CD_A_SCLH 8'h10
`define I2CD_A_SCLL 8'h14
// control fields
`define I2CD_C_EN 0
`define I2CD_C_WORD 1
`define I2CD_C_TRX 2
`define I2CD_C_MST 3
`define I2CD_C_STT 4
`define I2CD_C_SSEL_LO 5
`define I2CD_C_SSEL_HI 6
// status fields
`define I2CD_S_TXREADY 0
`define I2CD_S_RXREADY 1
`define I2CD_S_UNDER 2
`define I2CD_S_OVER 3
`define I2CD_S_STARTDET 4
`define I2CD_S_ACTIVE 5
`define I2CD_S_CLKREQ 6
// reset values
`define I2CD_CTRL_RST 7'h00
`define I2CD_PSC_RST 3'h0
`define I2CD_SCLH_RST 8'h05
`define I2CD_SCLL_RST 8'h05
// bus encodings
`define I2CD_HSIZE_BYTE 3'h0
`endif

/* logic/i2cd_sclgen.v */
`timescale 1ns/1ps
`default_nettype none
module i2cd_sclgen #(
  parameter CNTW = 8
) (
  input wire clock,
  input wire rst_b,
  input wire tickEn,
  input wire run,
  input wire [2:0] psc,
  input wire [CNTW-1:0] highCnt,
  input wire [CNTW-1:0] lowCnt,
  input wire holdLow,
  input wire sclIn,
  output wire sclOe,
  output wire lowPhase
);
  localparam ST_HIGH = 2'h0;
  localparam ST_LOW = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [2:0] pre_r;
  reg [1:0] state_r;
  reg [CNTW-1:0] cnt_r;
  wire pTick;
  wire [CNTW:0] lowLim;
  wire [CNTW:0] highLim;
  wire [CNTW:0] cntInc;

  // prescaled module clock tick
  assign pTick = tickEn && (pre_r == psc);
  assign lowLim = (lowCnt == 0) ? {{CNTW{1'b0}}, 1'b1} : {1'b0, lowCnt};
  assign highLim = (highCnt == 0) ? {{CNTW{1'b0}}, 1'b1} : {1'b0, highCnt};
  assign cntInc = {1'b0, cnt_r} + 1'b1;

  always @(posedge clock) begin
    if (!rst_b || !run) begin
      pre_r <= 3'h0;
    end else if (tickEn) begin
      pre_r <= pTick ? 3'h0 : pre_r + 3'h1;
    end
  end

  always @(posedge clock) begin
    if (!rst_b || !run) begin
      state_r <= ST_HIGH;
      cnt_r <= {CNTW{1'b0}};
    end else begin
      case (state_r)
        ST_LOW: begin
          if (pTick) begin
            if (cntInc >= lowLim) begin
              state_r <= ST_WAIT;
              cnt_r <= {CNTW{1'b0}};
            end else begin
              cnt_r <= cntInc[CNTW-1:0];
            end
          end
        end
        ST_WAIT: begin
          // high period starts only once the wire is released
          if (sclIn) begin
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (!sclIn) begin
            state_r <= ST_LOW;
            cnt_r <= {CNTW{1'b0}};
          end else if (pTick) begin
            if (cntInc >= highLim) begin
              state_r <= ST_LOW;
              cnt_r <= {CNTW{1'b0}};
            end else begin
              cnt_r <= cntInc[CNTW-1:0];
            end
          end
        end
        default: begin
          state_r <= ST_HIGH;
          cnt_r <= {CNTW{1'b0}};
        end
      endcase
    end
  end

  assign lowPhase = (state_r == ST_LOW);
  assign sclOe = (run && lowPhase) || holdLow;
endmodule // i2cd_sclgen
`default_nettype wire

/* logic/i2cd_top.v */
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2cd_defines.vh"
module i2cd_top #(
  parameter CNTW = 8
) (
  input wire clock,
  input wire rst_b,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  input wire [3:0] modClkEn,
  input wire [3:0] srcActive,
  output wire clkRequest,
  output wire fsmClkEn,
  input wire activity,
  input wire startAck,
  input wire startDetect,
  input wire slaveReq,
  input wire txShiftEmpty,
  input wire txLoad,
  output wire [7:0] txByte,
  output wire txByteValid,
  input wire rxByteValid,
  input wire [7:0] rxByte,
  input wire sclIn,
  output wire sclOut,
  output wire sclOe,
  output wire sclLowPhase
);
  reg ap_r;
  reg ack_r;
  reg [7:0] apAddr_r;
  reg apWrite_r;
  reg apByte_r;
  reg [31:0] hrdata_r;
  reg [6:0] ctrl_r;
  reg [2:0] psc_r;
  reg [CNTW-1:0] sclHigh_r;
  reg [CNTW-1:0] sclLow_r;
  reg [15:0] txReg_r;
  reg txRegFull_r;
  reg [15:0] txHold_r;
  reg txHoldFull_r;
  reg txHi_r;
  reg [15:0] txReg_nxt;
  reg txRegFull_nxt;
  reg [15:0] txHold_nxt;
  reg txHoldFull_nxt;
  reg txHi_nxt;
  reg [7:0] rxAsm_r;
  reg rxAsmHave_r;
  reg [15:0] rxShift_r;
  reg rxShiftFull_r;
  reg [15:0] rxHold_r;
  reg rxHoldFull_r;
  reg [15:0] rxReg_r;
  reg rxRegFull_r;
  reg [7:0] rxAsm_nxt;
  reg rxAsmHave_nxt;
  reg [15:0] rxShift_nxt;
  reg rxShiftFull_nxt;
  reg [15:0] rxHold_nxt;
  reg rxHoldFull_nxt;
  reg [15:0] rxReg_nxt;
  reg rxRegFull_nxt;
  reg txUnder_r;
  reg rxOver_r;
  reg startDet_r;
  reg clkReq_r;
  reg actPrev_r;
  reg sttPrev_r;
  reg [31:0] rdMux;

  wire accept;
  wire doAcc;
  wire wrEn;
  wire rdEn;
  wire enable;
  wire wordSel;
  wire trxDir;
  wire master;
  wire sttBit;
  wire [1:0] srcSel;
  wire dataWr;
  wire [15:0] wrVal;
  wire rxPop;
  wire underSet;
  wire overSet;
  wire rxStall;
  wire slvHold;
  wire actFall;
  wire reqSet;
  wire txReady;
  wire [6:0] status;

  assign enable = ctrl_r[`I2CD_C_EN];
  assign wordSel = ctrl_r[`I2CD_C_WORD];
  assign trxDir = ctrl_r[`I2CD_C_TRX];
  assign master = ctrl_r[`I2CD_C_MST];
  assign sttBit = ctrl_r[`I2CD_C_STT];
  assign srcSel = ctrl_r[`I2CD_C_SSEL_HI:`I2CD_C_SSEL_LO];

  // bus slave: one wait state, then OKAY
  assign accept = hsel && htrans[1] && hready;
  assign doAcc = ap_r && !ack_r;
  assign wrEn = doAcc && apWrite_r;
  assign rdEn = doAcc && !apWrite_r;
  assign hreadyout = !doAcc;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always @(posedge clock) begin
    if (!rst_b) begin
      ap_r <= 1'b0;
      ack_r <= 1'b0;
      apAddr_r <= 8'h00;
      apWrite_r <= 1'b0;
      apByte_r <= 1'b0;
    end else if (accept) begin
      ap_r <= 1'b1;
      ack_r <= 1'b0;
      apAddr_r <= {haddr[7:2], 2'b00};
      apWrite_r <= hwrite;
      apByte_r <= (hsize == `I2CD_HSIZE_BYTE);
    end else if (ack_r) begin
      ap_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (doAcc) begin
      ack_r <= 1'b1;
    end
  end

  assign txReady = enable && trxDir && !txHoldFull_r;
  assign status = {clkReq_r, activity, startDet_r, rxOver_r,
                   txUnder_r, rxRegFull_r, txReady};

  always @* begin
    rdMux = 32'h00000000;
    case (apAddr_r)
      `I2CD_A_CTRL: rdMux = {25'h0000000, ctrl_r};
      `I2CD_A_DATA: rdMux = {16'h0000, trxDir ? txReg_r : rxReg_r};
      `I2CD_A_STAT: rdMux = {25'h0000000, status};
      `I2CD_A_PSC: rdMux = {29'h00000000, psc_r};
      `I2CD_A_SCLH: rdMux[CNTW-1:0] = sclHigh_r;
      `I2CD_A_SCLL: rdMux[CNTW-1:0] = sclLow_r;
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      hrdata_r <= 32'h00000000;
    end else if (rdEn) begin
      hrdata_r <= rdMux;
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      ctrl_r <= `I2CD_CTRL_RST;
      psc_r <= `I2CD_PSC_RST;
      sclHigh_r <= `I2CD_SCLH_RST;
      sclLow_r <= `I2CD_SCLL_RST;
    end else begin
      if (wrEn && apAddr_r == `I2CD_A_CTRL) begin
        ctrl_r <= hwdata[6:0];
      end else if (startAck) begin
        ctrl_r[`I2CD_C_STT] <= 1'b0;
      end
      if (wrEn && apAddr_r == `I2CD_A_PSC) begin
        psc_r <= hwdata[2:0];
      end
      if (wrEn && apAddr_r == `I2CD_A_SCLH) begin
        sclHigh_r <= hwdata[CNTW-1:0];
      end
      if (wrEn && apAddr_r == `I2CD_A_SCLL) begin
        sclLow_r <= hwdata[CNTW-1:0];
      end
    end
  end

  // data register access
  assign dataWr = wrEn && apAddr_r == `I2CD_A_DATA &&
                  !(wordSel && apByte_r);
  assign wrVal = wordSel ? hwdata[15:0] : {8'h00, hwdata[7:0]};
  assign rxPop = rdEn && apAddr_r == `I2CD_A_DATA && enable && !trxDir;

  // transmit: data register plus holding buffer
  always @* begin
    txReg_nxt = txReg_r;
    txRegFull_nxt = txRegFull_r;
    txHold_nxt = txHold_r;
    txHoldFull_nxt = txHoldFull_r;
    txHi_nxt = txHi_r;
    if (!enable) begin
      txRegFull_nxt = 1'b0;
      txHoldFull_nxt = 1'b0;
      txHi_nxt = 1'b0;
    end else begin
      if (txLoad && txRegFull_r) begin
        if (wordSel && !txHi_r) begin
          txReg_nxt = {8'h00, txReg_r[15:8]};
          txHi_nxt = 1'b1;
        end else begin
          txHi_nxt = 1'b0;
          if (txHoldFull_r) begin
            txReg_nxt = txHold_r;
            txHoldFull_nxt = 1'b0;
          end else begin
            txRegFull_nxt = 1'b0;
          end
        end
      end
      if (dataWr && trxDir) begin
        if (!txRegFull_nxt) begin
          txReg_nxt = wrVal;
          txRegFull_nxt = 1'b1;
        end else if (!txHoldFull_nxt) begin
          txHold_nxt = wrVal;
          txHoldFull_nxt = 1'b1;
        end
      end
    end
  end

  // receive: assembler, shift stage, holding buffer, data register
  always @* begin
    rxAsm_nxt = rxAsm_r;
    rxAsmHave_nxt = rxAsmHave_r;
    rxShift_nxt = rxShift_r;
    rxShiftFull_nxt = rxShiftFull_r;
    rxHold_nxt = rxHold_r;
    rxHoldFull_nxt = rxHoldFull_r;
    rxReg_nxt = rxReg_r;
    rxRegFull_nxt = rxRegFull_r;
    if (!enable) begin
      rxAsmHave_nxt = 1'b0;
      rxShiftFull_nxt = 1'b0;
      rxHoldFull_nxt = 1'b0;
      rxRegFull_nxt = 1'b0;
    end else begin
      if (rxPop) begin
        rxRegFull_nxt = 1'b0;
      end
      if (rxHoldFull_nxt && !rxRegFull_nxt) begin
        rxReg_nxt = rxHold_nxt;
        rxRegFull_nxt = 1'b1;
        rxHoldFull_nxt = 1'b0;
      end
      if (rxShiftFull_nxt && !rxHoldFull_nxt) begin
        if (rxRegFull_nxt) begin
          rxHold_nxt = rxShift_nxt;
          rxHoldFull_nxt = 1'b1;
        end else begin
          rxReg_nxt = rxShift_nxt;
          rxRegFull_nxt = 1'b1;
        end
        rxShiftFull_nxt = 1'b0;
      end
      if (rxByteValid && !trxDir && !rxShiftFull_nxt) begin
        if (wordSel && !rxAsmHave_r) begin
          rxAsm_nxt = rxByte;
          rxAsmHave_nxt = 1'b1;
        end else begin
          rxShift_nxt = wordSel ? {rxByte, rxAsm_r} : {8'h00, rxByte};
          rxShiftFull_nxt = 1'b1;
          rxAsmHave_nxt = 1'b0;
        end
      end
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      txReg_r <= 16'h0000;
      txRegFull_r <= 1'b0;
      txHold_r <= 16'h0000;
      txHoldFull_r <= 1'b0;
      txHi_r <= 1'b0;
      rxAsm_r <= 8'h00;
      rxAsmHave_r <= 1'b0;
      rxShift_r <= 16'h0000;
      rxShiftFull_r <= 1'b0;
      rxHold_r <= 16'h0000;
      rxHoldFull_r <= 1'b0;
      rxReg_r <= 16'h0000;
      rxRegFull_r <= 1'b0;
    end else begin
      txReg_r <= txReg_nxt;
      txRegFull_r <= txRegFull_nxt;
      txHold_r <= txHold_nxt;
      txHoldFull_r <= txHoldFull_nxt;
      txHi_r <= txHi_nxt;
      rxAsm_r <= rxAsm_nxt;
      rxAsmHave_r <= rxAsmHave_nxt;
      rxShift_r <= rxShift_nxt;
      rxShiftFull_r <= rxShiftFull_nxt;
      rxHold_r <= rxHold_nxt;
      rxHoldFull_r <= rxHoldFull_nxt;
      rxReg_r <= rxReg_nxt;
      rxRegFull_r <= rxRegFull_nxt;
    end
  end

  assign txByte = txReg_r[7:0];
  assign txByteValid = enable && trxDir && txRegFull_r;

  // error flags: a set in the clearing cycle wins
  assign underSet = enable && trxDir && txShiftEmpty && !txRegFull_r &&
                    !txHoldFull_r &&
                    (master ? activity : slaveReq);
  assign rxStall = rxShiftFull_r && rxHoldFull_r;
  assign overSet = enable && !trxDir && rxStall;

  always @(posedge clock) begin
    if (!rst_b) begin
      txUnder_r <= 1'b0;
      rxOver_r <= 1'b0;
      startDet_r <= 1'b0;
    end else begin
      if (underSet) begin
        txUnder_r <= 1'b1;
      end else if (dataWr || !enable) begin
        txUnder_r <= 1'b0;
      end
      if (overSet) begin
        rxOver_r <= 1'b1;
      end else if (rxPop || !enable) begin
        rxOver_r <= 1'b0;
      end
      if (enable && !master && startDetect) begin
        startDet_r <= 1'b1;
      end else if (wrEn && apAddr_r == `I2CD_A_STAT &&
                   hwdata[`I2CD_S_STARTDET]) begin
        startDet_r <= 1'b0;
      end
    end
  end

  // automatic clock request
  assign actFall = actPrev_r && !activity;
  assign reqSet = enable && ((master && sttBit && !sttPrev_r) ||
                  (!master && startDetect));

  always @(posedge clock) begin
    if (!rst_b) begin
      clkReq_r <= 1'b0;
      actPrev_r <= 1'b0;
      sttPrev_r <= 1'b0;
    end else begin
      actPrev_r <= activity;
      sttPrev_r <= sttBit;
      if (reqSet) begin
        clkReq_r <= 1'b1;
      end else if (actFall || !enable) begin
        clkReq_r <= 1'b0;
      end
    end
  end

  // request drives the shared source for the whole chip
  assign clkRequest = clkReq_r;
  assign fsmClkEn = modClkEn[srcSel] &&
                    (activity || clkReq_r);
  assign slvHold = enable && !master && clkReq_r &&
                   !srcActive[srcSel];
  assign sclOut = 1'b0;

  i2cd_sclgen #(
    .CNTW(CNTW)
  ) u_sclgen (
    .clock(clock),
    .rst_b(rst_b),
    .tickEn(modClkEn[srcSel]),
    .run(enable && master && activity),
    .psc(psc_r),
    .highCnt(sclHigh_r),
    .lowCnt(sclLow_r),
    .holdLow(slvHold || (enable && rxStall)),
    .sclIn(sclIn),
    .sclOe(sclOe),
    .lowPhase(sclLowPhase)
  );
endmodule // i2cd_top
`default_nettype wire

/* verif/i2cd_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cd_bus_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclOe,
  input wire logic extLow,
  input wire logic [7:0] txByte,
  input wire logic txByteValid,
  output logic sclIn,
  output logic txLoad,
  output logic txShiftEmpty
);
  logic [2:0] cnt;
  logic [2:0] nGot;
  logic [7:0] got [0:7];
  // pulled-up wire, any party pulling low wins
  assign sclIn = !(sclOe || extLow);
  assign txShiftEmpty = (cnt == 3'h0);
  always @(posedge clock) begin
    txLoad <= 1'b0;
    if (!rst_b) begin
      cnt <= 3'h0;
      nGot <= 3'h0;
    end else if (txByteValid && txShiftEmpty && !txLoad) begin
      txLoad <= 1'b1;
      got[nGot] <= txByte;
      nGot <= nGot + 3'h1;
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule // i2cd_bus_model
`default_nettype wire

/* verif/i2cd_props.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cd_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic activity,
  input wire logic clkRequest,
  input wire logic fsmClkEn,
  input wire logic txLoad,
  input wire logic [7:0] txByte,
  input wire logic txByteValid,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sclLowPhase
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  AST_WAIT: assert property (
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  AST_TXHOLD: assert property (
    txByteValid && !txLoad |=> txByteValid && $stable(txByte))
    else $error("transmit byte changed before taken");
  AST_REQFALL: assert property (
    $fell(activity) |=> !clkRequest)
    else $error("clock request kept after idle");
  AST_REQHOLD: assert property (
    clkRequest && activity |=> clkRequest)
    else $error("clock request dropped while busy");
  AST_LOWOE: assert property (sclLowPhase |-> sclOe)
    else $error("low phase without pulling scl");
  AST_FSM: assert property (
    fsmClkEn |-> activity || clkRequest)
    else $error("state machine clocked while idle");
  AST_SCLOUT: assert property (sclOut == 1'b0)
    else $error("scl driven high");
  COV_TX: cover property (txByteValid && txLoad);
  COV_REQ: cover property ($rose(clkRequest));
  COV_LOW: cover property ($rose(sclLowPhase));
endmodule // i2cd_props
bind i2cd_top i2cd_props i2cd_props_inst (.clock, .rst_b, .hsel,
  .htrans, .hready, .hreadyout, .hresp, .activity, .clkRequest,
  .fsmClkEn, .txLoad, .txByte, .txByteValid, .sclOut, .sclOe,
  .sclLowPhase);
`default_nettype wire

/* verif/i2cd_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "i2cd_defines.vh"
module i2cd_top_test;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam int PSC = 1;
  localparam int SCLL = 3;
  logic clock, hsel = 1'b0, hwrite = 1'b0, rst_b = 1'b0;
  logic activity = 1'b0, startAck = 1'b0, startDetect = 1'b0;
  logic slaveReq = 1'b0, rxByteValid = 1'b0, extLow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [3:0] modClkEn = 4'h0, srcActive = 4'h0;
  logic [7:0] rxByte = 8'h00;
  wire logic hreadyout, hresp, clkRequest, fsmClkEn, txByteValid;
  wire logic sclIn, sclOut, sclOe, sclLowPhase, txLoad, txShiftEmpty;
  wire logic [31:0] hrdata;
  wire logic [7:0] txByte;
  int n_mismatch = 0, comparisons = 0, cyc = 0, n;
  i2cd_top i2cd_top_inst (.clock, .rst_b, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .modClkEn, .srcActive, .clkRequest, .fsmClkEn, .activity,
    .startAck, .startDetect, .slaveReq, .txShiftEmpty, .txLoad, .txByte,
    .txByteValid, .rxByteValid, .rxByte, .sclIn, .sclOut, .sclOe,
    .sclLowPhase);
  i2cd_bus_model i2cd_bus_model_inst (.clock, .rst_b, .sclOe, .extLow,
    .txByte, .txByteValid, .sclIn, .txLoad, .txShiftEmpty);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    modClkEn <= ~modClkEn;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 3'h2);
  endtask
  task rdChk(input logic [7:0] a, input logic [31:0] m, e);
    ahb(1'b0, a, 32'h0, 3'h2);
    chk(q & m, e);
  endtask
  task rxb(input logic [7:0] b);
    rxByte <= b;
    rxByteValid <= 1'b1;
    @(posedge clock);
    rxByteValid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task waitLow(input logic v);
    n = 0;
    while (sclLowPhase !== v && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk(sclLowPhase, v);
  endtask
  task tReset;
    rdChk(`I2CD_A_CTRL, ALL, 32'h0);
    rdChk(`I2CD_A_STAT, ALL, 32'h0);
    rdChk(`I2CD_A_PSC, ALL, 32'h0);
    rdChk(`I2CD_A_SCLH, ALL, {24'h0, `I2CD_SCLH_RST});
    rdChk(`I2CD_A_SCLL, ALL, {24'h0, `I2CD_SCLL_RST});
    wr(8'h18, ALL);
    rdChk(8'h18, ALL, 32'h0);
  endtask
  task tTx;
    wr(`I2CD_A_CTRL, 32'h07);
    wr(`I2CD_A_DATA, 32'hBBAA);
    ahb(1'b1, `I2CD_A_DATA, 32'h11, `I2CD_HSIZE_BYTE);
    repeat (20) @(posedge clock);
    chk(i2cd_bus_model_inst.nGot, 2);
    chk(i2cd_bus_model_inst.got[0], 8'hAA);
    chk(i2cd_bus_model_inst.got[1], 8'hBB);
    rdChk(`I2CD_A_STAT, 32'h4, 32'h0);
    slaveReq <= 1'b1;
    repeat (3) @(posedge clock);
    rdChk(`I2CD_A_STAT, 32'h4, 32'h4);
    // drop the request so the clear is not beaten by a fresh set
    slaveReq <= 1'b0;
    wr(`I2CD_A_DATA, 32'hDDCC);
    rdChk(`I2CD_A_STAT, 32'h4, 32'h0);
    slaveReq <= 1'b1;
    repeat (20) @(posedge clock);
    chk(i2cd_bus_model_inst.got[2], 8'hCC);
    chk(i2cd_bus_model_inst.got[3], 8'hDD);
    rdChk(`I2CD_A_STAT, 32'h4, 32'h4);
    wr(`I2CD_A_CTRL, 32'h0);
    rdChk(`I2CD_A_STAT, 32'h4, 32'h0);
    slaveReq <= 1'b0;
    wr(`I2CD_A_CTRL, 32'h05);
    ahb(1'b1, `I2CD_A_DATA, 32'h31, `I2CD_HSIZE_BYTE);
    ahb(1'b1, `I2CD_A_DATA, 32'h32, `I2CD_HSIZE_BYTE);
    // third byte lands while the register is full and waits in the hold
    ahb(1'b1, `I2CD_A_DATA, 32'h33, `I2CD_HSIZE_BYTE);
    repeat (20) @(posedge clock);
    chk(i2cd_bus_model_inst.got[4], 8'h31);
    chk(i2cd_bus_model_inst.got[5], 8'h32);
    chk(i2cd_bus_model_inst.got[6], 8'h33);
    activity <= 1'b1;
    wr(`I2CD_A_CTRL, 32'h0D);
    rdChk(`I2CD_A_STAT, 32'h4, 32'h4);
    activity <= 1'b0;
    wr(`I2CD_A_CTRL, 32'h0);
  endtask
  task tRx;
    wr(`I2CD_A_CTRL, 32'h01);
    rxb(8'h11);
    rxb(8'h22);
    rxb(8'h33);
    rdChk(`I2CD_A_STAT, 32'h8, 32'h8);
    chk(sclOe, 1'b1);
    rdChk(`I2CD_A_DATA, ALL, 32'h11);
    // stall still stood at that read, so the set won over the clear
    rdChk(`I2CD_A_STAT, 32'h8, 32'h8);
    chk(sclOe, 1'b0);
    rdChk(`I2CD_A_DATA, ALL, 32'h22);
    rdChk(`I2CD_A_STAT, 32'h8, 32'h0);
    rdChk(`I2CD_A_DATA, ALL, 32'h33);
    rdChk(`I2CD_A_STAT, 32'h2, 32'h0);
    wr(`I2CD_A_CTRL, 32'h03);
    rxb(8'h44);
    rxb(8'h55);
    rdChk(`I2CD_A_STAT, 32'h2, 32'h2);
    rdChk(`I2CD_A_DATA, ALL, 32'h5544);
    rdChk(`I2CD_A_STAT, 32'h2, 32'h0);
    wr(`I2CD_A_CTRL, 32'h0);
  endtask
  task tMaster;
    wr(`I2CD_A_PSC, PSC);
    wr(`I2CD_A_SCLH, 32'h7);
    wr(`I2CD_A_SCLL, SCLL);
    activity <= 1'b1;
    wr(`I2CD_A_CTRL, 32'h1D);
    rdChk(`I2CD_A_STAT, 32'h41, 32'h41);
    chk(fsmClkEn, modClkEn[0]);
    waitLow(1'b0);
    waitLow(1'b1);
    waitLow(1'b0);
    chk(n, SCLL * (PSC + 1) * 2);
    extLow <= 1'b1;
    repeat (4) @(posedge clock);
    chk(sclLowPhase, 1'b1);
    waitLow(1'b0);
    repeat (4) @(posedge clock);
    chk(sclOe, 1'b0);
    extLow <= 1'b0;
    startAck <= 1'b1;
    @(posedge clock);
    startAck <= 1'b0;
    activity <= 1'b0;
    repeat (2) @(posedge clock);
    chk(clkRequest, 1'b0);
    chk(fsmClkEn, 1'b0);
    wr(`I2CD_A_CTRL, 32'h0);
  endtask
  task tSlave;
    // source two selected
    wr(`I2CD_A_CTRL, 32'h41);
    activity <= 1'b1;
    startDetect <= 1'b1;
    @(posedge clock);
    startDetect <= 1'b0;
    repeat (2) @(posedge clock);
    chk(sclOe, 1'b1);
    rdChk(`I2CD_A_STAT, 32'h50, 32'h50);
    srcActive <= 4'hB;
    repeat (3) @(posedge clock);
    chk(sclOe, 1'b1);
    srcActive <= 4'h4;
    repeat (3) @(posedge clock);
    chk(sclOe, 1'b0);
    wr(`I2CD_A_STAT, 32'h10);
    rdChk(`I2CD_A_STAT, 32'h10, 32'h0);
    activity <= 1'b0;
    repeat (2) @(posedge clock);
    chk(clkRequest, 1'b0);
    srcActive <= 4'h0;
    wr(`I2CD_A_CTRL, 32'h0);
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    tReset();
    tTx();
    tRx();
    tMaster();
    tSlave();
    results();
  end
endmodule // i2cd_top_test
`default_nettype wire
